// *** src/host_buffer_regs_pkg.sv ***
package host_buffer_regs_pkg;

	// command codes: read codes have bit 7 clear, write codes have it set
	localparam logic [7:0] CMD_RD_SCRATCH = 8'h28;
	localparam logic [7:0] CMD_WR_SCRATCH = 8'hA8;
	localparam logic [7:0] CMD_WR_SOFT_RESET = 8'hA9;
	localparam logic [7:0] CMD_RD_ISO_SIZE = 8'h2A;
	localparam logic [7:0] CMD_WR_ISO_SIZE = 8'hAA;
	localparam logic [7:0] CMD_RD_ASYNC_SIZE = 8'h2B;
	localparam logic [7:0] CMD_WR_ASYNC_SIZE = 8'hAB;
	localparam logic [7:0] CMD_RD_BUFFER_FLAGS = 8'h2C;
	localparam logic [7:0] CMD_RD_ISO0_COUNT = 8'h2D;

	localparam logic [15:0] SOFT_RESET_CODE = 16'h00F6;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [15:0] UNMAPPED_READ = 16'h0000;
	localparam logic [12:0] BUFFER_RAM_BYTES = 13'h1000;

	// buffer index inside the three-bit flag vectors
	localparam int BUF_ISO_ZERO = 0;
	localparam int BUF_ISO_ONE = 1;
	localparam int BUF_ASYNC = 2;
	localparam int NUM_BUFFERS = 3;

	// status word layout
	localparam int LOADED_LSB = 0;
	localparam int CONSUMED_LSB = 3;
	localparam int FLAGS_USED = 6;

	// command from the shared processor bus interface
	typedef struct packed {
		logic strobe;
		logic [7:0] code;
		logic [15:0] data;
	} bus_cmd_type;

	// one-cycle events from the host engine, one bit per buffer
	typedef struct packed {
		logic [NUM_BUFFERS-1:0] loaded_set;
		logic [NUM_BUFFERS-1:0] loaded_clear;
		logic [NUM_BUFFERS-1:0] consumed_set;
		logic [NUM_BUFFERS-1:0] consumed_clear;
	} buffer_event_type;

	// readback byte count update from the host engine
	typedef struct packed {
		logic load;
		logic [15:0] count;
	} count_update_type;

endpackage : host_buffer_regs_pkg

// *** src/host_buffer_ram_control_regs.sv ***
`timescale 1ns/1ps
// Overview of operation
// - a 16-bit scratch register is read with code 28 and written with code A8, keeps the last write and resets to zero.
// - writing F6H to the reset trigger returns every register to its reset value and leaves buffer RAM alone.
// - the reset trigger is a write-only 16-bit location at code A9H that cannot be read.
// - one 16-bit value at codes 2A/AA sizes both isochronous buffers, so they are always equal.
// - a 16-bit register at codes 2B/AB sets the asynchronous buffer size.
// - a read-only 16-bit status register at 2CH has bits 15 to 6 reading as zero.
// - status bits 5, 4, 3 show async, iso one, iso zero as consumed by the host controller.
// - status bits 2, 1, 0 show async, iso one, iso zero as full (1) or empty (0).
// - a read-only register at 2DH holds the bytes left in iso buffer zero for readback.
// - both buffer size registers are read/write over bits 15 to 0 and reset to zero.
module host_buffer_ram_control_regs (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// processor bus command, same clock domain
	input host_buffer_regs_pkg::bus_cmd_type bus_cmd,
	output logic [15:0] rd_data,
	output logic rd_valid,
	// host engine events
	input host_buffer_regs_pkg::buffer_event_type buffer_events,
	input host_buffer_regs_pkg::count_update_type iso0_count_update,
	// configuration to the buffer RAM arbiter and the rest of the controller
	output logic [15:0] iso_size_field,
	output logic [15:0] async_size_field,
	output logic soft_reset_pulse
);
	import host_buffer_regs_pkg::*;

	logic [15:0] scratch_store;
	logic [15:0] iso_buffer_size;
	logic [15:0] async_buffer_size;
	logic [15:0] iso0_readback_count;
	logic [NUM_BUFFERS-1:0] loaded;
	logic [NUM_BUFFERS-1:0] consumed;
	logic [15:0] buffer_flags;
	logic soft_reset_hit;
	logic wr_scratch;
	logic wr_iso;
	logic wr_async;

	// other values at the trigger fall through and change nothing
	assign soft_reset_hit = bus_cmd.strobe && bus_cmd.code == CMD_WR_SOFT_RESET
		&& bus_cmd.data == SOFT_RESET_CODE;
	assign wr_scratch = bus_cmd.strobe && bus_cmd.code == CMD_WR_SCRATCH;
	assign wr_iso = bus_cmd.strobe && bus_cmd.code == CMD_WR_ISO_SIZE;
	assign wr_async = bus_cmd.strobe && bus_cmd.code == CMD_WR_ASYNC_SIZE;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			scratch_store <= REG_RESET;
		end else if (soft_reset_hit) begin
			scratch_store <= REG_RESET;
		end else if (wr_scratch) begin
			scratch_store <= bus_cmd.data;
		end
	end

	// sizes are stored as written; no fit check, software owns the RAM budget
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			iso_buffer_size <= REG_RESET;
			async_buffer_size <= REG_RESET;
		end else if (soft_reset_hit) begin
			iso_buffer_size <= REG_RESET;
			async_buffer_size <= REG_RESET;
		end else begin
			if (wr_iso) begin
				iso_buffer_size <= bus_cmd.data;
			end
			if (wr_async) begin
				async_buffer_size <= bus_cmd.data;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			iso0_readback_count <= REG_RESET;
		end else if (soft_reset_hit) begin
			iso0_readback_count <= REG_RESET;
		end else if (iso0_count_update.load) begin
			iso0_readback_count <= iso0_count_update.count;
		end
	end

	// per-buffer sticky flags; a set in the same cycle as a clear wins
	generate
		for (genvar b = 0; b < NUM_BUFFERS; b++) begin : g_flags
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					loaded[b] <= 1'b0;
					consumed[b] <= 1'b0;
				end else if (soft_reset_hit) begin
					loaded[b] <= 1'b0;
					consumed[b] <= 1'b0;
				end else begin
					if (buffer_events.loaded_set[b]) begin
						loaded[b] <= 1'b1;
					end else if (buffer_events.loaded_clear[b]) begin
						loaded[b] <= 1'b0;
					end
					if (buffer_events.consumed_set[b]) begin
						consumed[b] <= 1'b1;
					end else if (buffer_events.consumed_clear[b]) begin
						consumed[b] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	always_comb begin
		buffer_flags = REG_RESET;
		buffer_flags[LOADED_LSB +: NUM_BUFFERS] = loaded;
		buffer_flags[CONSUMED_LSB +: NUM_BUFFERS] = consumed;
	end

	// read answer one cycle after the command; the trigger reads as unmapped
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rd_data <= UNMAPPED_READ;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= bus_cmd.strobe && !bus_cmd.code[7];
			if (bus_cmd.strobe && !bus_cmd.code[7]) begin
				unique case (bus_cmd.code)
					CMD_RD_SCRATCH: rd_data <= scratch_store;
					CMD_RD_ISO_SIZE: rd_data <= iso_buffer_size;
					CMD_RD_ASYNC_SIZE: rd_data <= async_buffer_size;
					CMD_RD_BUFFER_FLAGS: rd_data <= buffer_flags;
					CMD_RD_ISO0_COUNT: rd_data <= iso0_readback_count;
					default: rd_data <= UNMAPPED_READ;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			iso_size_field <= REG_RESET;
			async_size_field <= REG_RESET;
			soft_reset_pulse <= 1'b0;
		end else begin
			iso_size_field <= iso_buffer_size;
			async_size_field <= async_buffer_size;
			soft_reset_pulse <= soft_reset_hit;
		end
	end

endmodule : host_buffer_ram_control_regs

// *** testbench/hbr_monitor.sv ***
`timescale 1ns/1ps
module hbr_checker (
	// watched design ports
	input wire logic sys_clk,
	input wire logic rst,
	input host_buffer_regs_pkg::bus_cmd_type bus_cmd,
	input wire logic [15:0] rd_data,
	input wire logic rd_valid,
	input host_buffer_regs_pkg::buffer_event_type buffer_events,
	input host_buffer_regs_pkg::count_update_type iso0_count_update,
	input wire logic [15:0] iso_size_field,
	input wire logic [15:0] async_size_field,
	input wire logic soft_reset_pulse
);
	import host_buffer_regs_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic st;
	logic kill;
	assign st = bus_cmd.strobe;
	assign kill = st && bus_cmd.code == CMD_WR_SOFT_RESET && bus_cmd.data == SOFT_RESET_CODE;
	sequence s_cmd(c);
		st && bus_cmd.code == c;
	endsequence
	a_read_answered: assert property (st && !bus_cmd.code[7] |=> rd_valid)
		else $error("read not answered");
	a_scratch_echo: assert property (s_cmd(CMD_WR_SCRATCH) ##1 s_cmd(CMD_RD_SCRATCH)
		|=> rd_data == $past(bus_cmd.data, 2)) else $error("scratch lost");
	a_reset_pulse: assert property (kill |=> soft_reset_pulse)
		else $error("no soft reset pulse");
	a_reset_ignored: assert property (st && bus_cmd.code == CMD_WR_SOFT_RESET && !kill
		|=> !soft_reset_pulse) else $error("bad code reset");
	a_iso_follow: assert property (s_cmd(CMD_WR_ISO_SIZE) |=> ##1
		iso_size_field == $past(bus_cmd.data, 2)) else $error("iso size out");
	a_flags_reserved: assert property (s_cmd(CMD_RD_BUFFER_FLAGS) |=> rd_data[15:6] == 0)
		else $error("reserved bits set");
	a_loaded_seen: assert property (buffer_events.loaded_set[BUF_ASYNC] && !kill
		##1 s_cmd(CMD_RD_BUFFER_FLAGS) |=> rd_data[2]) else $error("flag lost");
	a_count_read: assert property (iso0_count_update.load && !kill
		##1 s_cmd(CMD_RD_ISO0_COUNT) |=> rd_data == $past(iso0_count_update.count, 2))
		else $error("count lost");
endmodule : hbr_checker
bind host_buffer_ram_control_regs hbr_checker hbr_checker_inst (.sys_clk, .rst, .bus_cmd,
	.rd_data, .rd_valid, .buffer_events, .iso0_count_update, .iso_size_field,
	.async_size_field, .soft_reset_pulse);

// *** testbench/proc_model.sv ***
`timescale 1ns/1ps
module proc_model (
	// command bus toward the device
	input wire logic sys_clk,
	output host_buffer_regs_pkg::bus_cmd_type bus_cmd,
	input wire logic [15:0] rd_data,
	input wire logic rd_valid
);
	import host_buffer_regs_pkg::*;
	initial bus_cmd = '0;
	// strobe stays up so a following command goes back to back; sizes are not checked against the RAM
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(posedge sys_clk);
		bus_cmd <= '{1'b1, c, d};
	endtask : wr
	// a missing answer reads as unknown so it can never match
	task automatic rd(input logic [7:0] c, output logic [15:0] d);
		@(posedge sys_clk);
		bus_cmd <= '{1'b1, c, ~bus_cmd.data};
		@(posedge sys_clk);
		bus_cmd.strobe <= 1'b0;
		// the answer is registered on the taking edge and stands for one cycle only
		#1 d = rd_valid ? rd_data : 16'hxxxx;
	endtask : rd
endmodule : proc_model

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
	import host_buffer_regs_pkg::*;
	localparam logic [7:0] RDS [5] = '{8'h28, 8'h2A, 8'h2B, 8'h2C, 8'h2D};
	logic sys_clk, rst, rd_valid, soft_reset_pulse;
	logic [15:0] rd_data, iso_size_field, async_size_field;
	wire bus_cmd_type bus_cmd;
	buffer_event_type buffer_events;
	count_update_type iso0_count_update;
	int fail_count, check_count;
	host_buffer_ram_control_regs host_buffer_ram_control_regs_inst (.sys_clk, .rst, .bus_cmd,
		.rd_data, .rd_valid, .buffer_events, .iso0_count_update, .iso_size_field,
		.async_size_field, .soft_reset_pulse);
	proc_model proc_model_inst (.sys_clk, .bus_cmd, .rd_data, .rd_valid);
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic rdc(input logic [7:0] c, input logic [15:0] e);
		logic [15:0] v;
		proc_model_inst.rd(c, v);
		chk($sformatf("code %h", c), e, v);
	endtask : rdc
	// event and count inputs are held until changed, flags being sticky
	task automatic ev(input buffer_event_type e, input count_update_type u);
		@(posedge sys_clk);
		buffer_events <= e;
		iso0_count_update <= u;
	endtask : ev
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : stop_test
	initial begin
		#20000;
		fail_count++;
		stop_test();
	end
	initial begin
		rst = 1'b1;
		buffer_events = '0;
		iso0_count_update = '0;
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		foreach (RDS[i]) rdc(RDS[i], REG_RESET);
		$display("test reset_values done");
		proc_model_inst.wr(CMD_WR_SCRATCH, 16'h1234);
		rdc(CMD_RD_SCRATCH, 16'h1234);
		proc_model_inst.wr(CMD_WR_ISO_SIZE, 16'hFFFF);
		proc_model_inst.wr(CMD_WR_ASYNC_SIZE, 16'h0800);
		rdc(CMD_RD_ISO_SIZE, 16'hFFFF);
		rdc(CMD_RD_ASYNC_SIZE, 16'h0800);
		chk("iso size out", 16'hFFFF, iso_size_field);
		chk("async size out", 16'h0800, async_size_field);
		rdc({1'b0, CMD_WR_SOFT_RESET[6:0]}, UNMAPPED_READ);
		rdc(8'h2E, UNMAPPED_READ);
		$display("test access done");
		ev('{3'b111, 3'b000, 3'b111, 3'b000}, '{1'b1, 16'h0123});
		rdc(CMD_RD_BUFFER_FLAGS, 16'h003F);
		rdc(CMD_RD_ISO0_COUNT, 16'h0123);
		ev('{3'b000, 3'b101, 3'b000, 3'b010}, '0);
		rdc(CMD_RD_BUFFER_FLAGS, 16'h002A);
		ev('0, '0);
		$display("test flags done");
		proc_model_inst.wr(CMD_WR_SOFT_RESET, 16'h00F7);
		rdc(CMD_RD_SCRATCH, 16'h1234);
		proc_model_inst.wr(CMD_WR_SOFT_RESET, SOFT_RESET_CODE);
		@(posedge sys_clk);
		#1 chk("soft reset pulse", 16'h0001, {15'h0000, soft_reset_pulse});
		foreach (RDS[i]) rdc(RDS[i], REG_RESET);
		$display("test soft_reset done");
		stop_test();
	end
endmodule : testbench
